// ---- hdl/vcs_id_filter.sv ----
// Purpose: synchronise the id pins and accept a code after three agreeing samples
// Assumes: pins are asynchronous to clk
// Notes:   one sample per SAMPLE_CYC clocks
`timescale 1ns/10ps
module vcs_id_filter #(
  parameter int W = 6,
  parameter int SAMPLE_CYC = vcs_pkg::SAMPLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // id pins
  input wire logic [W-1:0] idPins,
  // accepted code
  output logic [W-1:0] idCode,
  output logic idValid
);

  localparam int DW = $clog2(SAMPLE_CYC + 1);

  logic [W-1:0] sync1_q, sync2_q, smp0_q, smp1_q, smp2_q;
  logic [DW-1:0] divCnt_q;
  logic sampleEn_q;
  logic [1:0] nSmp_q;
  logic agree;

  // two-flop synchroniser; first flop feeds only the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= idPins;
      sync2_q <= sync1_q;
    end
  end

  // divider making the sample enable, one pulse per SAMPLE_CYC (6) clocks, about 16.7 MHz at 100 MHz
  always_ff @(posedge clk) begin
    if (!nrst) begin
      divCnt_q <= '0;
      sampleEn_q <= 1'b0;
    end else if (divCnt_q == DW'(SAMPLE_CYC - 1)) begin
      divCnt_q <= '0;
      sampleEn_q <= 1'b1;
    end else begin
      divCnt_q <= divCnt_q + 1'b1;
      sampleEn_q <= 1'b0;
    end
  end

  // three-deep sample history; count guards against stale reset values
  always_ff @(posedge clk) begin
    if (!nrst) begin
      smp0_q <= '0;
      smp1_q <= '0;
      smp2_q <= '0;
      nSmp_q <= 2'h0;
    end else if (sampleEn_q) begin
      smp0_q <= sync2_q;
      smp1_q <= smp0_q;
      smp2_q <= smp1_q;
      if (nSmp_q != 2'h3) nSmp_q <= nSmp_q + 2'h1;
    end
  end

  // a glitch seen by only one or two samples never reaches the stepper
  assign agree = (nSmp_q == 2'h3) && (smp0_q == smp1_q) && (smp1_q == smp2_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      idCode <= '0;
      idValid <= 1'b0;
    end else if (agree) begin
      idCode <= smp0_q;
      idValid <= 1'b1;
    end
  end

  a_accept_agree: assert property (@(posedge clk) disable iff (!nrst)
    $changed(idCode) |-> $past(agree)) else $error("code accepted without agreement");

  a_sample_rate: assert property (@(posedge clk) disable iff (!nrst)
    sampleEn_q |=> !sampleEn_q [*5] ##1 sampleEn_q) else $error("sample enable off pace");

endmodule

// ---- hdl/vcs_pkg.sv ----
// Purpose: shared constants and types of the voltage code stepper
// Assumes: 100 MHz system clock
// Notes:   levels are expressed in units of 100 uV
package vcs_pkg;

  // ************************************************************
  // clocking and timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SAMPLE_PERIOD_PS = 62500; // 16 MHz sample clock
  localparam int SAMPLE_CYC = (SAMPLE_PERIOD_PS / CLK_PERIOD_PS) < 1 ? 1 :
                              (SAMPLE_PERIOD_PS / CLK_PERIOD_PS);
  localparam int STEP_PERIOD_NS = 4000; // one internal step cycle, 4 us
  localparam int STEP_CYC = (STEP_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int HALF_CYC = STEP_CYC / 2;
  localparam int CNT_W = 9;

  // ************************************************************
  // code and level encoding
  // ************************************************************
  localparam int CODE_W = 6;
  localparam int LEVEL_W = 14;
  localparam logic [5:0] OFF_CODE = 6'h3F;
  localparam logic [5:0] CODE_RESET = 6'h00;
  localparam int BASE_LEVEL = 5250; // 0.525 V in 100 uV units
  localparam int STEP_LEVEL = 125; // 12.5 mV in 100 uV units

  // stepper states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_PACE = 3'h4
  } vcs_state_t;

  // reference handed to the converter
  typedef struct packed {
    logic on;
    logic [5:0] code;
    logic [13:0] level;
  } vcs_ref_t;

endpackage

// ---- hdl/vcs_stepper.sv ----
// Purpose: step the converter reference code toward the requested id code
// Assumes: one 100 MHz clock; nrst is a synchronous reset, shutdown is the all-ones off code
// Notes:   level and code outputs lag the code register by one clock
`timescale 1ns/10ps
module vcs_stepper #(
  parameter int STEP_CYC = vcs_pkg::STEP_CYC,
  parameter int HALF_CYC = vcs_pkg::HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // id pins from the processor, bit 0 is voltage_id_bit_lsb, bit 5 the msb
  input wire logic [5:0] voltageIdCode,
  // reference to the converter
  output vcs_pkg::vcs_ref_t referenceLevel
);

  // ************************************************************
  // input filter
  // ************************************************************
  logic [5:0] tgt;
  logic tgtValid;

  vcs_id_filter #(
    .W(vcs_pkg::CODE_W),
    .SAMPLE_CYC(vcs_pkg::SAMPLE_CYC)
  ) u_filter (
    .clk(clk),
    .nrst(nrst),
    .idPins(voltageIdCode),
    .idCode(tgt),
    .idValid(tgtValid)
  );

  // ************************************************************
  // request decode
  // ************************************************************
  vcs_pkg::vcs_state_t state_q, state_d;
  logic [5:0] refCode_q;
  logic [vcs_pkg::CNT_W-1:0] cnt_q;
  logic refOn_q, dirUp_q;
  logic offReq, initLoad, up, dn, flip, stepFire, codeWr;

  // all-ones is the no-load request
  assign offReq = tgtValid && (tgt == vcs_pkg::OFF_CODE);
  assign initLoad = tgtValid && !offReq && !refOn_q;
  assign up = tgt > refCode_q;
  assign dn = tgt < refCode_q;
  // reaching equality also counts as a flip: nothing left to do
  assign flip = dirUp_q ? !up : !dn;

  // ************************************************************
  // step state machine
  // ************************************************************
  // next state and step strobe
  always_comb begin
    state_d = state_q;
    stepFire = 1'b0;
    unique case (state_q)
      vcs_pkg::ST_IDLE: begin
        if (refOn_q && !offReq && (up || dn)) state_d = vcs_pkg::ST_WAIT;
      end
      vcs_pkg::ST_WAIT: begin
        if (offReq || flip) begin
          state_d = vcs_pkg::ST_IDLE;
        end else if (cnt_q == vcs_pkg::CNT_W'(HALF_CYC - 1)) begin
          stepFire = 1'b1;
          state_d = vcs_pkg::ST_PACE;
        end
      end
      vcs_pkg::ST_PACE: begin
        if (offReq || !(up || dn)) begin
          state_d = vcs_pkg::ST_IDLE;
        end else if (cnt_q == vcs_pkg::CNT_W'(STEP_CYC - 1)) begin
          stepFire = 1'b1;
        end
      end
      default: state_d = vcs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) state_q <= vcs_pkg::ST_IDLE;
    else state_q <= state_d;
  end

  // pacing counter restarts on every state change and every step
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (stepFire || (state_d != state_q)) begin
      cnt_q <= '0;
    end else if (state_q != vcs_pkg::ST_IDLE) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // direction latched when the wait starts, for the sign check
  always_ff @(posedge clk) begin
    if (!nrst) dirUp_q <= 1'b0;
    else if (state_q == vcs_pkg::ST_IDLE) dirUp_q <= up;
  end

  // ************************************************************
  // reference register
  // ************************************************************
  // enable tracks shutdown; the stored code survives shutdown
  always_ff @(posedge clk) begin
    if (!nrst) refOn_q <= 1'b0;
    else if (offReq) refOn_q <= 1'b0;
    else if (tgtValid) refOn_q <= 1'b1;
  end

  assign codeWr = stepFire || initLoad;

  // only a step or the wake-up load writes the code; wake-up loads it directly
  always_ff @(posedge clk) begin
    if (!nrst) begin
      refCode_q <= vcs_pkg::CODE_RESET;
    end else if (initLoad) begin
      refCode_q <= tgt;
    end else if (stepFire) begin
      refCode_q <= up ? refCode_q + 6'h01 : refCode_q - 6'h01;
    end
  end

  // level = 0.525 V + code * 12.5 mV, so the msb weighs 400 mV
  always_ff @(posedge clk) begin
    if (!nrst) begin
      referenceLevel <= '0;
    end else begin
      referenceLevel.on <= refOn_q;
      referenceLevel.code <= refCode_q;
      referenceLevel.level <= refOn_q ? vcs_pkg::LEVEL_W'(vcs_pkg::BASE_LEVEL +
        int'(refCode_q) * vcs_pkg::STEP_LEVEL) : '0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // helper: cycles since the last step and cycles in the current state
  logic [10:0] sinceStep_q, dwell_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sinceStep_q <= 11'h7FF;
      dwell_q <= 11'h000;
    end else begin
      sinceStep_q <= stepFire ? 11'h000 : (sinceStep_q == 11'h7FF ? sinceStep_q :
                     sinceStep_q + 11'h001);
      dwell_q <= (state_d != state_q) ? 11'h000 : (dwell_q == 11'h7FF ? dwell_q :
                 dwell_q + 11'h001);
    end
  end

  sequence s_flip;
    (state_q == vcs_pkg::ST_WAIT) && !offReq && flip;
  endsequence

  a_level_decode: assert property (@(posedge clk) disable iff (!nrst)
    referenceLevel.on |-> int'(referenceLevel.level) ==
      vcs_pkg::BASE_LEVEL + int'(referenceLevel.code) * vcs_pkg::STEP_LEVEL)
    else $error("level does not match code");

  a_off_code: assert property (@(posedge clk) disable iff (!nrst)
    offReq |-> ##2 (!referenceLevel.on && referenceLevel.level == '0))
    else $error("off code did not shut reference");

  a_one_step: assert property (@(posedge clk) disable iff (!nrst)
    stepFire |=> (refCode_q == $past(refCode_q) + 6'h01) ||
      (refCode_q == $past(refCode_q) - 6'h01)) else $error("step not one lsb");

  a_half_wait: assert property (@(posedge clk) disable iff (!nrst)
    stepFire && (state_q == vcs_pkg::ST_WAIT) |-> int'(dwell_q) == HALF_CYC - 1)
    else $error("first step not after half cycle");

  a_pace_gap: assert property (@(posedge clk) disable iff (!nrst)
    stepFire && (state_q == vcs_pkg::ST_PACE) |-> int'(sinceStep_q) == STEP_CYC - 1)
    else $error("steps not one step cycle apart");

  a_cancel_hold: assert property (@(posedge clk) disable iff (!nrst)
    s_flip |=> (state_q == vcs_pkg::ST_IDLE) && $stable(refCode_q))
    else $error("flipped request still stepped");

  a_code_source: assert property (@(posedge clk) disable iff (!nrst)
    $changed(refCode_q) |-> $past(codeWr)) else $error("code written outside stepping");

  a_state_onehot: assert property (@(posedge clk) disable iff (!nrst)
    $onehot(state_q)) else $error("state not one-hot");

  // ************************************************************
  // wait, idle, wake-up, shutdown and direction checks
  // ************************************************************
  // a wait opens from idle while a change is pending
  sequence s_wait_open;
    (state_q == vcs_pkg::ST_IDLE) && (state_d == vcs_pkg::ST_WAIT);
  endsequence

  // a stale count here would shorten the half wait and skew every later step
  sequence s_wait_fresh;
    (state_q == vcs_pkg::ST_WAIT) && (cnt_q == '0);
  endsequence

  a_wait_fresh: assert property (@(posedge clk) disable iff (!nrst)
    s_wait_open |=> s_wait_fresh) else $error("wait did not start from a cleared count");

  // shutdown drops any pending or paced step at once
  a_off_idle: assert property (@(posedge clk) disable iff (!nrst)
    offReq |=> (state_q == vcs_pkg::ST_IDLE) && !stepFire)
    else $error("stepper active in shutdown");

  // idle means the code is left alone while regulating
  a_idle_hold: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == vcs_pkg::ST_IDLE) && refOn_q |=> $stable(refCode_q))
    else $error("code moved while idle");

  // wake-up takes the accepted code as it stands; any ramp lives outside
  a_wake_load: assert property (@(posedge clk) disable iff (!nrst)
    initLoad |=> refOn_q && (refCode_q == $past(tgt)))
    else $error("wake-up did not load the accepted code");

  // an upward request may only ever raise the code
  a_step_toward: assert property (@(posedge clk) disable iff (!nrst)
    stepFire && up |=> refCode_q == $past(refCode_q) + 6'h01)
    else $error("upward request stepped down");

endmodule

// ---- tb/testbench.sv ----
// Purpose: self-checking bench of the voltage code stepper
// Assumes: step timing shortened to 80/40 clocks
// Notes:   waits are bounded; a hang ends the run as a failure
`timescale 1ns/10ps
module testbench;
  localparam int STEP = 80;
  localparam int HALF = 40;
  typedef struct packed {
    logic [5:0] code;
    logic [13:0] level;
  } vcs_row_t;
  logic clk;
  logic nrst;
  logic paced;
  logic [5:0] target;
  logic [5:0] voltageIdCode;
  logic [5:0] lastCode = 6'h00;
  vcs_pkg::vcs_ref_t referenceLevel;
  int nMismatch = 0;
  int comparisons = 0;
  int n;
  // codes beside the level each should give, in 100 uV units
  vcs_row_t rows[8] = '{'{6'h00, 14'h1482}, '{6'h01, 14'h14FF}, '{6'h02, 14'h157C},
    '{6'h04, 14'h1676}, '{6'h08, 14'h186A}, '{6'h10, 14'h1C52}, '{6'h20, 14'h2422},
    '{6'h3E, 14'h32C8}};

  vcs_stepper #(.STEP_CYC(STEP), .HALF_CYC(HALF)) u_dut (.clk(clk), .nrst(nrst),
    .voltageIdCode(voltageIdCode), .referenceLevel(referenceLevel));
  vcs_cpu_model #(.PACE(STEP)) u_cpu (.clk(clk), .target(target), .paced(paced),
    .pins(voltageIdCode));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic end_sim();
    if (nMismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_ref(input vcs_pkg::vcs_ref_t exp);
    comparisons++;
    if (referenceLevel !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, referenceLevel, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      nMismatch++;
      $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  // level is registered in the same clock as the enable; settle two clocks before comparing
  task automatic wait_on(input logic on);
    int k;
    k = 0;
    while (referenceLevel.on !== on && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k >= 200) begin
      nMismatch++;
      end_sim();
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic wait_chg(output int k);
    logic [5:0] old;
    old = referenceLevel.code;
    k = 0;
    while (referenceLevel.code === old && k < 1000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 1000) begin
      nMismatch++;
      end_sim();
    end
  endtask
  // off then wake, which loads the code without stepping
  task automatic wake(input logic [5:0] code, input logic [13:0] lvl);
    target = 6'h3F;
    wait_on(1'b0);
    chk_ref({1'b0, lastCode, 14'h0000});
    target = code;
    wait_on(1'b1);
    chk_ref({1'b1, code, lvl});
    lastCode = code;
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    paced = 1'b0;
    target = 6'h3F;
    repeat (10) @(negedge clk);
    chk_ref('0);
    nrst = 1'b1;
    foreach (rows[i]) begin
      wake(rows[i].code, rows[i].level);
    end
    wake(6'h10, 14'h1C52);
    target = 6'h11;
    wait_chg(n);
    chk_cnt(n, HALF + 18, HALF + 25);
    repeat (2) @(negedge clk);
    chk_ref({1'b1, 6'h11, 14'h1CCF});
    target = 6'h15;
    wait_chg(n);
    for (int s = 0; s < 3; s++) begin
      wait_chg(n);
      chk_cnt(n, STEP, STEP);
    end
    repeat (2) @(negedge clk);
    chk_ref({1'b1, 6'h15, 14'h1EC3});
    // reversal inside the half wait leaves the reference alone
    target = 6'h16;
    repeat (25) @(negedge clk);
    target = 6'h15;
    repeat (200) @(negedge clk);
    chk_ref({1'b1, 6'h15, 14'h1EC3});
    // a glitch shorter than one sample period is never accepted
    target = 6'h00;
    repeat (3) @(negedge clk);
    target = 6'h15;
    repeat (100) @(negedge clk);
    chk_ref({1'b1, 6'h15, 14'h1EC3});
    // a reversal across the reference cancels the upward step; a fresh wait walks down
    target = 6'h16;
    repeat (25) @(negedge clk);
    target = 6'h14;
    wait_chg(n);
    chk_cnt(n, HALF + 18, HALF + 26);
    chk_ref({1'b1, 6'h14, 14'h1E46});
    paced = 1'b1;
    target = 6'h18;
    repeat (4) wait_chg(n);
    repeat (2) @(negedge clk);
    chk_ref({1'b1, 6'h18, 14'h203A});
    paced = 1'b0;
    target = 6'h3F;
    wait_on(1'b0);
    chk_ref({1'b0, 6'h18, 14'h0000});
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk_ref('0);
    end_sim();
  end
endmodule

// ---- tb/vcs_cpu_model.sv ----
// Purpose: processor side model driving the voltage id pins
// Assumes: driven on the falling edge of clk
// Notes:   paced mode moves one lsb per PACE clocks
`timescale 1ns/10ps
module vcs_cpu_model #(
  parameter int PACE = 80
) (
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic [5:0] target,
  input wire logic paced,
  // id pins
  output logic [5:0] pins
);
  int cnt = 0;
  logic [5:0] want = 6'h3F;
  initial pins = 6'h3F;
  // next pin value is worked out on the rising edge, where the bench's
  // falling-edge writes of target and paced have settled, so nothing races
  // paced mode walks one lsb at a time so the device never sees a jump
  always @(posedge clk) begin
    cnt <= (cnt == 0) ? PACE - 1 : cnt - 1;
    if (!paced) begin
      want <= target;
    end else if (cnt == 0 && want != target) begin
      want <= (want < target) ? want + 6'h01 : want - 6'h01;
    end
  end
  // pins move on the falling edge, half a period away from the sampling edge
  always @(negedge clk) begin
    pins <= want;
  end
endmodule
